/* File: hdl/vcu_comparator_control.sv */
// Digital control around the on-chip voltage comparator
`timescale 1ns/1ns
`default_nettype none
`include "vcu_map.svh"

module vcu_comparator_control
  import vcu_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Power mode from system controller
  input wire vcu_power_t power_mode,
  // Software control writes
  input wire logic wr_strobe,
  input wire logic comparator_enable_wr,
  input wire logic bandgap_select_wr,
  input wire logic compare_irq_enable_wr,
  input wire logic output_pin_enable_wr,
  input wire logic [1:0] edge_select_wr,
  input wire logic flag_clear_wr,
  input wire logic capture_route_select_wr,
  // Analog comparator and pins
  input wire logic comparator_raw,
  input wire logic timer_capture_pin_zero,
  // Control readback
  output logic comparator_enable,
  output logic bandgap_select,
  output logic compare_irq_enable,
  output logic output_pin_enable,
  output logic [1:0] edge_select,
  output logic capture_route_select,
  // Status and analog controls
  output logic compare_event_flag,
  output logic comparator_level,
  output logic compare_irq,
  output logic comparator_active,
  output logic timer_capture_in_zero
);

  logic [`VCU_SYNC_STAGES-1:0] sync_reg;
  logic prev_reg;
  logic en_reg, bg_reg, ie_reg, ope_reg, route_reg, flag_reg, lvl_reg, irq_reg, act_reg, cap_reg;
  logic [1:0] mode_reg;
  logic flag_next, lvl_next, cap_next;

  wire logic deep_stop = (power_mode == VCU_STOP_DEEP);
  wire logic any_stop = deep_stop || (power_mode == VCU_STOP_LIGHT);
  // Comparing only while enabled and not stopped; wait keeps running
  wire logic running = en_reg && !any_stop;
  wire logic sync_out = sync_reg[`VCU_SYNC_STAGES-1];
  wire logic rise = sync_out && !prev_reg;
  wire logic fall = !sync_out && prev_reg;
  wire logic edge_hit = running && (
    ((mode_reg == `VCU_MODE_RISE) && rise) ||
    (((mode_reg == `VCU_MODE_FALL0) || (mode_reg == `VCU_MODE_FALL2)) && fall) ||
    ((mode_reg == `VCU_MODE_BOTH) && (rise || fall)));
  wire logic clr = wr_strobe && flag_clear_wr;

  assign flag_next = edge_hit || (flag_reg && !clr);
  assign lvl_next = en_reg && !any_stop ? sync_out : (en_reg ? lvl_reg : `VCU_RST_BIT);
  // Routed: timer sees comparator, external pin ignored
  assign cap_next = route_reg ? (running && sync_out) : timer_capture_pin_zero;

  // Synchroniser; first stage read only by second
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= {sync_reg[`VCU_SYNC_STAGES-2:0], comparator_raw};
    end
  end

  // Control bits; deep stop returns all to reset, light stop holds
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      en_reg <= `VCU_RST_BIT;
      bg_reg <= `VCU_RST_BIT;
      ie_reg <= `VCU_RST_BIT;
      ope_reg <= `VCU_RST_BIT;
      mode_reg <= `VCU_RST_MODE;
      route_reg <= `VCU_RST_BIT;
    end else if (deep_stop) begin
      en_reg <= `VCU_RST_BIT;
      bg_reg <= `VCU_RST_BIT;
      ie_reg <= `VCU_RST_BIT;
      ope_reg <= `VCU_RST_BIT;
      mode_reg <= `VCU_RST_MODE;
      route_reg <= `VCU_RST_BIT;
    end else if (wr_strobe && !any_stop) begin
      en_reg <= comparator_enable_wr;
      bg_reg <= bandgap_select_wr;
      ie_reg <= compare_irq_enable_wr;
      ope_reg <= output_pin_enable_wr;
      mode_reg <= edge_select_wr;
      route_reg <= capture_route_select_wr;
    end
  end

  // Status
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_reg <= `VCU_RST_BIT;
      flag_reg <= `VCU_RST_BIT;
      lvl_reg <= `VCU_RST_BIT;
      irq_reg <= `VCU_RST_BIT;
      act_reg <= `VCU_RST_BIT;
      cap_reg <= `VCU_RST_BIT;
    end else if (deep_stop) begin
      prev_reg <= `VCU_RST_BIT;
      flag_reg <= `VCU_RST_BIT;
      lvl_reg <= `VCU_RST_BIT;
      irq_reg <= `VCU_RST_BIT;
      act_reg <= `VCU_RST_BIT;
      cap_reg <= `VCU_RST_BIT;
    end else begin
      prev_reg <= running ? sync_out : prev_reg;
      flag_reg <= any_stop ? flag_reg : flag_next;
      lvl_reg <= lvl_next;
      irq_reg <= ie_reg && flag_reg;
      act_reg <= running;
      cap_reg <= cap_next;
    end
  end

  assign comparator_enable = en_reg;
  assign bandgap_select = bg_reg;
  assign compare_irq_enable = ie_reg;
  assign output_pin_enable = ope_reg;
  assign edge_select = mode_reg;
  assign capture_route_select = route_reg;
  assign compare_event_flag = flag_reg;
  assign comparator_level = lvl_reg;
  assign compare_irq = irq_reg;
  assign comparator_active = act_reg;
  assign timer_capture_in_zero = cap_reg;

  // Checks
  sequence s_rise_seen;
    running && rise && (mode_reg == `VCU_MODE_RISE);
  endsequence

  property p_flag_set;
    @(posedge ref_clk) disable iff (rst) s_rise_seen |=> compare_event_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on rise");

  property p_set_wins;
    @(posedge ref_clk) disable iff (rst) (edge_hit && clr && !deep_stop) |=> compare_event_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat event");

  property p_irq;
    @(posedge ref_clk) disable iff (rst) (ie_reg && flag_reg && !deep_stop) |=> compare_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_stop_quiet;
    @(posedge ref_clk) disable iff (rst) any_stop |=> !comparator_active;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("active in stop");

  property p_deep_reset;
    @(posedge ref_clk) disable iff (rst) deep_stop |=> !comparator_enable && !compare_event_flag;
  endproperty
  a_deep_reset: assert property (p_deep_reset) else $error("deep stop kept state");

  property p_light_hold;
    @(posedge ref_clk) disable iff (rst)
      (power_mode == VCU_STOP_LIGHT) |=> $stable(edge_select) && $stable(comparator_enable);
  endproperty
  a_light_hold: assert property (p_light_hold) else $error("light stop changed regs");

  property p_level_zero;
    @(posedge ref_clk) disable iff (rst) !en_reg |=> !comparator_level;
  endproperty
  a_level_zero: assert property (p_level_zero) else $error("level not zero");

  property p_route;
    @(posedge ref_clk) disable iff (rst)
      (route_reg && running && !deep_stop) |=> timer_capture_in_zero == $past(sync_out);
  endproperty
  a_route: assert property (p_route) else $error("capture not routed");

  sequence s_fall_seen;
    running && fall && ((mode_reg == `VCU_MODE_FALL0) || (mode_reg == `VCU_MODE_FALL2));
  endsequence

  sequence s_both_seen;
    running && (rise || fall) && (mode_reg == `VCU_MODE_BOTH);
  endsequence

  property p_flag_fall;
    @(posedge ref_clk) disable iff (rst) s_fall_seen |=> compare_event_flag;
  endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("flag not set on fall");

  property p_flag_both;
    @(posedge ref_clk) disable iff (rst) s_both_seen |=> compare_event_flag;
  endproperty
  a_flag_both: assert property (p_flag_both) else $error("flag not set on toggle");

  property p_flag_hold;
    @(posedge ref_clk) disable iff (rst) (flag_reg && !clr && !deep_stop) |=> compare_event_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

  property p_flag_clear;
    @(posedge ref_clk) disable iff (rst) (clr && !edge_hit && !any_stop) |=> !compare_event_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_flag_quiet;
    @(posedge ref_clk) disable iff (rst) (!flag_reg && !edge_hit) |=> !compare_event_flag;
  endproperty
  a_flag_quiet: assert property (p_flag_quiet) else $error("flag set without event");

  property p_irq_off;
    @(posedge ref_clk) disable iff (rst) !(ie_reg && flag_reg) |=> !compare_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without cause");

  property p_wait_runs;
    @(posedge ref_clk) disable iff (rst) ((power_mode == VCU_WAIT) && en_reg) |=> comparator_active;
  endproperty
  a_wait_runs: assert property (p_wait_runs) else $error("stopped in wait");

  property p_wait_irq;
    @(posedge ref_clk) disable iff (rst)
      ((power_mode == VCU_WAIT) && edge_hit && ie_reg && !wr_strobe) ##1 !deep_stop |=> compare_irq;
  endproperty
  a_wait_irq: assert property (p_wait_irq) else $error("no wake in wait");

  property p_stop_no_flag;
    @(posedge ref_clk) disable iff (rst) (any_stop && !flag_reg) |=> !compare_event_flag;
  endproperty
  a_stop_no_flag: assert property (p_stop_no_flag) else $error("event in stop");

  property p_light_flag;
    @(posedge ref_clk) disable iff (rst) (power_mode == VCU_STOP_LIGHT) |=> $stable(compare_event_flag);
  endproperty
  a_light_flag: assert property (p_light_flag) else $error("flag changed in light stop");

  property p_light_level;
    @(posedge ref_clk) disable iff (rst)
      ((power_mode == VCU_STOP_LIGHT) && en_reg) |=> $stable(comparator_level);
  endproperty
  a_light_level: assert property (p_light_level) else $error("level changed in light stop");

  property p_light_ctrl;
    @(posedge ref_clk) disable iff (rst) (power_mode == VCU_STOP_LIGHT) |=>
      $stable(capture_route_select) && $stable(compare_irq_enable) && $stable(bandgap_select);
  endproperty
  a_light_ctrl: assert property (p_light_ctrl) else $error("state lost in light stop");

  property p_deep_all;
    @(posedge ref_clk) disable iff (rst) deep_stop |=> !bandgap_select && !compare_irq_enable &&
      !capture_route_select && (edge_select == `VCU_RST_MODE) && !compare_irq;
  endproperty
  a_deep_all: assert property (p_deep_all) else $error("deep stop kept control");

  property p_write_taken;
    @(posedge ref_clk) disable iff (rst) (wr_strobe && !any_stop) |=>
      (edge_select == $past(edge_select_wr)) && (comparator_enable == $past(comparator_enable_wr));
  endproperty
  a_write_taken: assert property (p_write_taken) else $error("mode write lost");

  property p_bandgap;
    @(posedge ref_clk) disable iff (rst)
      (wr_strobe && !any_stop) |=> bandgap_select == $past(bandgap_select_wr);
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("bandgap write lost");

  property p_pin_reserved;
    @(posedge ref_clk) disable iff (rst)
      (wr_strobe && !any_stop) |=> output_pin_enable == $past(output_pin_enable_wr);
  endproperty
  a_pin_reserved: assert property (p_pin_reserved) else $error("reserved bit lost");

  property p_unrouted;
    @(posedge ref_clk) disable iff (rst)
      (!route_reg && !deep_stop) |=> timer_capture_in_zero == $past(timer_capture_pin_zero);
  endproperty
  a_unrouted: assert property (p_unrouted) else $error("pin not passed");

  property p_routed_idle;
    @(posedge ref_clk) disable iff (rst) (route_reg && !running) |=> !timer_capture_in_zero;
  endproperty
  a_routed_idle: assert property (p_routed_idle) else $error("routed output not idle");

  property p_level_live;
    @(posedge ref_clk) disable iff (rst) running |=> comparator_level == $past(sync_out);
  endproperty
  a_level_live: assert property (p_level_live) else $error("level not live");

  property p_sync_delay;
    @(posedge ref_clk) disable iff (rst) 1'h1 |=> sync_out == $past(sync_reg[0]);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync skipped a stage");

  property p_act_on;
    @(posedge ref_clk) disable iff (rst) running |=> comparator_active;
  endproperty
  a_act_on: assert property (p_act_on) else $error("enabled but idle");

endmodule
`default_nettype wire

/* File: hdl/vcu_map.svh */
// Synchroniser depth, edge mode codes and reset values for the comparator control block
`ifndef VCU_MAP_SVH
`define VCU_MAP_SVH
`define VCU_SYNC_STAGES 2
`define VCU_MODE_FALL0 2'h0
`define VCU_MODE_RISE 2'h1
`define VCU_MODE_FALL2 2'h2
`define VCU_MODE_BOTH 2'h3
`define VCU_RST_MODE 2'h0
`define VCU_RST_BIT 1'h0
`endif

/* File: hdl/vcu_pkg.sv */
// Types for the comparator control block
package vcu_pkg;
  typedef enum logic [1:0] {
    VCU_RUN = 2'h0,
    VCU_WAIT = 2'h1,
    VCU_STOP_LIGHT = 2'h3,
    VCU_STOP_DEEP = 2'h2
  } vcu_power_t;
endpackage

/* File: tb/vcu_analog_model.sv */
// Model of the analog comparator and the external capture pin
`timescale 1ns/1ns
`default_nettype none
module vcu_analog_model (
  // Bench control
  input wire logic cmp_level,
  input wire logic pin_level,
  // Device side
  input wire logic comparator_active,
  output logic comparator_raw,
  output logic timer_capture_pin_zero
);
  // Unpowered output shows the inverse so a stale level never passes
  assign comparator_raw = comparator_active ? cmp_level : ~cmp_level;
  assign timer_capture_pin_zero = pin_level;
endmodule
`default_nettype wire

/* File: tb/comparator_control_logic_tb_top.sv */
// Self-checking bench for the comparator control block
`timescale 1ns/1ns
`default_nettype none
module comparator_control_logic_tb_top import vcu_pkg::*;;
  logic ref_clk = 1'h0, rst = 1'h1, wr_strobe = 1'h0, cmp = 1'h0, pin = 1'h0;
  logic en_w = 1'h0, bg_w = 1'h0, ie_w = 1'h0, ope_w = 1'h0, clr_w = 1'h0, rt_w = 1'h0;
  logic [1:0] mode_w = 2'h0;
  vcu_power_t power_mode = VCU_RUN;
  logic raw, pin_in, c_en, bg, ie, ope, rt, flag, lvl, irq, act, cap;
  logic [1:0] mode;
  int errors = 0, n_compared = 0, cycles = 0;
  always #50 ref_clk = ~ref_clk;
  vcu_analog_model model_u (.cmp_level(cmp), .pin_level(pin), .comparator_active(act),
    .comparator_raw(raw), .timer_capture_pin_zero(pin_in));
  vcu_comparator_control dut_u (.ref_clk(ref_clk), .rst(rst), .power_mode(power_mode),
    .wr_strobe(wr_strobe), .comparator_enable_wr(en_w), .bandgap_select_wr(bg_w),
    .compare_irq_enable_wr(ie_w), .output_pin_enable_wr(ope_w), .edge_select_wr(mode_w),
    .flag_clear_wr(clr_w), .capture_route_select_wr(rt_w), .comparator_raw(raw),
    .timer_capture_pin_zero(pin_in), .comparator_enable(c_en), .bandgap_select(bg),
    .compare_irq_enable(ie), .output_pin_enable(ope), .edge_select(mode),
    .capture_route_select(rt), .compare_event_flag(flag), .comparator_level(lvl),
    .compare_irq(irq), .comparator_active(act), .timer_capture_in_zero(cap));
  task automatic final_report();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Field order: enable, bandgap, irq enable, pin enable, mode, clear, route
  task automatic wr(input logic [7:0] v);
    @(posedge ref_clk);
    {en_w, bg_w, ie_w, ope_w, mode_w, clr_w, rt_w} <= v;
    wr_strobe <= 1'h1;
    @(posedge ref_clk);
    wr_strobe <= 1'h0;
    step(1);
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'h0;
    step(1);
    chk(flag, 1'h0);
    chk(act, 1'h0);
    for (int m = 0; m < 4; m++) begin
      wr(8'ha2 | 8'(m << 2));
      step(6);
      wr(8'ha2 | 8'(m << 2));
      chk(flag, 1'h0);
      chk(mode == 2'(m), 1'h1);
      chk(ie, 1'h1);
      @(posedge ref_clk) cmp <= 1'h1;
      step(6);
      chk(flag, 1'(m % 2));
      chk(irq, 1'(m % 2));
      chk(lvl, 1'h1);
      wr(8'ha2 | 8'(m << 2));
      @(posedge ref_clk) cmp <= 1'h0;
      step(6);
      chk(flag, 1'(m != 1));
    end
    wr(8'hc5);
    @(posedge ref_clk) pin <= 1'h1;
    step(6);
    chk(bg, 1'h1);
    chk(rt, 1'h1);
    chk(cap, 1'h0);
    @(posedge ref_clk) cmp <= 1'h1;
    step(6);
    chk(cap, 1'h1);
    wr(8'h84);
    @(posedge ref_clk) pin <= 1'h0;
    step(2);
    chk(cap, 1'h0);
    wr(8'hae);
    @(posedge ref_clk) power_mode <= VCU_WAIT;
    cmp <= 1'h0;
    step(6);
    chk(flag, 1'h1);
    chk(irq, 1'h1);
    @(posedge ref_clk) power_mode <= VCU_STOP_LIGHT;
    step(2);
    chk(act, 1'h0);
    wr(8'h02);
    chk(flag, 1'h1);
    chk(c_en, 1'h1);
    @(posedge ref_clk) power_mode <= VCU_RUN;
    step(2);
    chk(act, 1'h1);
    @(posedge ref_clk) power_mode <= VCU_STOP_DEEP;
    step(2);
    @(posedge ref_clk) power_mode <= VCU_RUN;
    step(2);
    chk(c_en, 1'h0);
    chk(flag, 1'h0);
    wr(8'h90);
    chk(ope, 1'h1);
    wr(8'h00);
    chk(lvl, 1'h0);
    final_report();
  end
endmodule
`default_nettype wire
